// [src/psemc_pkg.sv]
/*
 Shared constants for the four-port power controller mode and reset block:
 register offsets, field positions, mode and response codes and timing figures.
 Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package psemc_pkg;
    localparam int          NUM_PORTS       = 4;
    localparam logic [7:0]  REG_STATUS      = 8'h00;
    localparam logic [7:0]  REG_PORT_MODE   = 8'h48;
    localparam logic [7:0]  REG_DET_CLS     = 8'h50;
    localparam logic [7:0]  REG_CADENCE     = 8'h54;
    localparam logic [7:0]  REG_POWER_ON    = 8'h64;
    localparam logic [7:0]  REG_RESET       = 8'h68;
    localparam logic [7:0]  REG_EVENT       = 8'h70;
    localparam int          CHIP_RST_BIT    = 4;
    localparam logic [1:0]  MODE_SHUTDOWN   = 2'h0;
    localparam logic [1:0]  MODE_MANUAL     = 2'h1;
    localparam logic [1:0]  MODE_SEMI       = 2'h2;
    localparam logic [1:0]  MODE_AUTO       = 2'h3;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam int          CLK_HZ          = 25000000;
    localparam int          EN_LOW_MIN_US   = 100;
    localparam int          EN_LOW_CYCLES   = (EN_LOW_MIN_US * (CLK_HZ / 1000000));
    localparam int          CADENCE_S       = 2;
    localparam int          CADENCE_CYCLES  = CADENCE_S * CLK_HZ;
    localparam int          DET_CYCLES      = 16;
    localparam int          CLS_CYCLES      = 16;
endpackage : psemc_pkg

// [src/psemc_top.sv]
/*
 Mode and reset control of a four-port power-sourcing controller, with
 AXI4-Lite register access and an open-drain interrupt pin.
 Assumes strap, enable and analog status pins are asynchronous; the
 detection and classification front end reports pass/fail per port.
*/
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Class-5 strap pulls low; high at latch enables class-5 classification.
// - Default-mode strap pulls high; high gives auto, low gives shutdown.
// - Cadence strap pulls high; high at latch enables cadence timing.
// - Interrupt pin is driven low while an interrupt is signalled.
// - Undervoltage lockout holds the whole device in reset.
// - Enable pin low at least 100 us resets; release when high.
// - Chip soft-reset bit resets everything and clears itself.
// - Over-temperature holds shutdown; full reset when flag clears.
// - Straps sampled only at the end of each reset.
// - Port reset on powered port: off, requests off, events cleared; the code clears only the port's detect event, not its classify event.
// - With cadence, failed detection waits two seconds before retry.
// - Per-port cadence bits also enable cadence timing.
// - Mode changes among active modes keep operation; shutdown idles port.
// - Mode code 11 selects auto mode.
// - Auto mode detects, classifies, powers; otherwise repeats detection.
// - Auto from reset sets request bits; by software keeps them.
// - Code 10 semiautomatic: repeats allowed cycles, never powers itself.
// - Semi power-on request powers only after successful detect and classify.
// - Semi port powering down clears its detect and classify requests.
// - Code 01 manual clears requests; each request runs once then clears.
// - Manual power-on request wins and powers the port at once.
// - Manual detect runs before classify; powered port ignores requests.
// - Code 00 shutdown: power off, events clear, requests ignored; the code clears only the detect events, not the classify events.
module psemc_top
    import psemc_pkg::*;
#(
    parameter int EN_LOW_CNT  = EN_LOW_CYCLES,
    parameter int CADENCE_CNT = CADENCE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        en_pin,
    input  wire logic        undervoltage_lockout,
    input  wire logic        over_temp,
    input  wire logic        class5_enable_strap,
    input  wire logic        default_mode_strap,
    input  wire logic        cadence_strap,
    input  wire logic [3:0]  address_straps,
    input  wire logic [3:0]  det_good,
    input  wire logic [3:0]  cls_good,
    input  wire logic [3:0]  power_fault,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [3:0]       port_power,
    output logic [3:0]       port_detecting,
    output logic [3:0]       port_classifying,
    output logic             class5_enabled,
    output logic [3:0]       address_latched,
    output logic             int_n_out,
    output logic             int_n_oe
);
    typedef enum {PS_IDLE, PS_DETECT, PS_CLASSIFY, PS_WAIT, PS_POWERED} psemc_port_t;

    // Input synchronisers
    logic [14:0] sync1;
    logic [14:0] sync2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 15'h4000;
            sync2 <= 15'h4000;
        end else begin
            sync1 <= {en_pin, undervoltage_lockout, over_temp, class5_enable_strap,
                      default_mode_strap, cadence_strap, address_straps, det_good, 1'b0};
            sync2 <= sync1;
        end
    end
    logic       en_s, undervoltage_lockout_s, ot_s;
    logic [3:0] det_s;
    assign en_s   = sync2[14];
    assign undervoltage_lockout_s = sync2[13];
    assign ot_s   = sync2[12];
    assign det_s  = sync2[4:1];
    logic [3:0] cls_s1, cls_s2, flt_s1, flt_s2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cls_s1 <= 4'h0;
            cls_s2 <= 4'h0;
            flt_s1 <= 4'h0;
            flt_s2 <= 4'h0;
        end else begin
            cls_s1 <= cls_good;
            cls_s2 <= cls_s1;
            flt_s1 <= power_fault;
            flt_s2 <= flt_s1;
        end
    end

    // Global reset sources
    logic [31:0] en_low_cnt;
    logic        en_reset;
    logic        chip_rst_req;
    logic        glob_rst;
    logic        glob_rst_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_low_cnt <= 32'h00000000;
            en_reset   <= 1'b0;
        end else if (en_s) begin
            en_low_cnt <= 32'h00000000;
            en_reset   <= 1'b0;
        end else if (en_low_cnt >= 32'(EN_LOW_CNT - 1)) begin
            en_reset   <= 1'b1;
        end else begin
            en_low_cnt <= en_low_cnt + 32'h00000001;
        end
    end
    // Power-up reset stretched until the strap synchronisers hold pin values
    logic [1:0]  boot_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_cnt <= 2'h3;
        end else if (boot_cnt != 2'h0) begin
            boot_cnt <= boot_cnt - 2'h1;
        end
    end
    assign glob_rst = undervoltage_lockout_s || en_reset || ot_s || chip_rst_req
                      || boot_cnt != 2'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            glob_rst_q <= 1'b1;
        end else begin
            glob_rst_q <= glob_rst;
        end
    end

    // Straps latched at the end of each reset
    logic mode_auto_def;
    logic cadence_def;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            class5_enabled  <= 1'b0;
            mode_auto_def   <= 1'b1;
            cadence_def     <= 1'b1;
            address_latched <= 4'hF;
        end else if (glob_rst) begin
            class5_enabled  <= sync2[11];
            mode_auto_def   <= sync2[10];
            cadence_def     <= sync2[9];
            address_latched <= sync2[8:5];
        end
    end

    // Register bus
    logic [7:0]  mode_reg;
    logic [7:0]  req_reg;
    logic [3:0]  cadence_reg;
    logic [3:0]  pwr_req;
    logic [3:0]  port_rst_req;
    logic [7:0]  event_reg;
    logic        aw_held, w_held, w_lane0;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        wr_fire;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_lane0       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    REG_PORT_MODE, REG_DET_CLS, REG_CADENCE, REG_POWER_ON,
                    REG_RESET, REG_STATUS, REG_EVENT: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    logic wr_lane0;
    assign wr_lane0 = wr_fire && w_lane0;

    // Port state machines
    psemc_port_t pstate [NUM_PORTS];
    logic [31:0] pcnt   [NUM_PORTS];
    logic [3:0]  det_ok, cls_ok;
    logic [3:0]  cadence_on;
    assign cadence_on = cadence_reg | {4{cadence_def}};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_rst_req <= 1'b0;
        end else begin
            chip_rst_req <= wr_lane0 && aw_addr == REG_RESET
                            && w_data[CHIP_RST_BIT];
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [1:0] md;
            logic       shut, semi, man, auto_m;
            logic       mode_wr, req_wr, pwr_wr, rst_wr, port_rst;
            assign md      = mode_reg[2*p+1:2*p];
            assign shut    = md == MODE_SHUTDOWN;
            assign man     = md == MODE_MANUAL;
            assign semi    = md == MODE_SEMI;
            assign auto_m  = md == MODE_AUTO;
            assign mode_wr = wr_lane0 && aw_addr == REG_PORT_MODE;
            assign req_wr  = wr_lane0 && aw_addr == REG_DET_CLS;
            assign pwr_wr  = wr_lane0 && aw_addr == REG_POWER_ON && w_data[p];
            assign rst_wr  = wr_lane0 && aw_addr == REG_RESET && w_data[p];
            assign port_rst = rst_wr && pstate[p] == PS_POWERED;

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mode_reg[2*p+1:2*p] <= MODE_AUTO;
                    req_reg[p]          <= 1'b1;
                    req_reg[p+4]        <= 1'b1;
                    cadence_reg[p]      <= 1'b0;
                    pwr_req[p]          <= 1'b0;
                    port_rst_req[p]     <= 1'b0;
                    event_reg[p]        <= 1'b0;
                    event_reg[p+4]      <= 1'b0;
                    pstate[p]           <= PS_IDLE;
                    pcnt[p]             <= 32'h00000000;
                    det_ok[p]           <= 1'b0;
                    cls_ok[p]           <= 1'b0;
                end else if (glob_rst) begin
                    mode_reg[2*p+1:2*p] <= sync2[10] ? MODE_AUTO : MODE_SHUTDOWN;
                    req_reg[p]          <= sync2[10];
                    req_reg[p+4]        <= sync2[10];
                    cadence_reg[p]      <= 1'b0;
                    pwr_req[p]          <= 1'b0;
                    port_rst_req[p]     <= 1'b0;
                    event_reg[p]        <= 1'b0;
                    event_reg[p+4]      <= 1'b0;
                    pstate[p]           <= PS_IDLE;
                    pcnt[p]             <= 32'h00000000;
                    det_ok[p]           <= 1'b0;
                    cls_ok[p]           <= 1'b0;
                end else begin
                    port_rst_req[p] <= port_rst;
                    pwr_req[p]      <= 1'b0;
                    if (mode_wr) begin
                        mode_reg[2*p+1:2*p] <= w_data[2*p+1 -: 2];
                        if (w_data[2*p+1 -: 2] == MODE_MANUAL) begin
                            req_reg[p]   <= 1'b0;
                            req_reg[p+4] <= 1'b0;
                        end
                    end else if (req_wr && !shut) begin
                        req_reg[p]   <= w_data[p];
                        req_reg[p+4] <= w_data[p+4];
                    end
                    if (wr_lane0 && aw_addr == REG_CADENCE) begin
                        cadence_reg[p] <= w_data[p];
                    end
                    if (pwr_wr && !shut) begin
                        pwr_req[p] <= 1'b1;
                    end
                    if (wr_lane0 && aw_addr == REG_EVENT && w_data[p]) begin
                        event_reg[p] <= 1'b0;
                    end
                    if (shut || port_rst) begin
                        pstate[p]    <= PS_IDLE;
                        event_reg[p] <= 1'b0;
                        det_ok[p]    <= 1'b0;
                        cls_ok[p]    <= 1'b0;
                        if (port_rst) begin
                            req_reg[p]   <= 1'b0;
                            req_reg[p+4] <= 1'b0;
                            event_reg[p] <= 1'b0;
                        end
                    end else begin
                        case (pstate[p])
                            PS_IDLE: begin
                                if (man && pwr_req[p]) begin
                                    pstate[p] <= PS_POWERED;
                                end else if (semi && pwr_req[p] && det_ok[p] && cls_ok[p]) begin
                                    pstate[p] <= PS_POWERED;
                                end else if (req_reg[p]) begin
                                    pstate[p] <= PS_DETECT;
                                    pcnt[p]   <= 32'h00000000;
                                end else if (req_reg[p+4] && !auto_m) begin
                                    pstate[p] <= PS_CLASSIFY;
                                    pcnt[p]   <= 32'h00000000;
                                end
                            end
                            PS_DETECT: begin
                                pcnt[p] <= pcnt[p] + 32'h00000001;
                                if ((man || (semi && det_ok[p] && cls_ok[p])) && pwr_req[p]) begin
                                    pstate[p] <= PS_POWERED;
                                end else if (pcnt[p] == 32'(DET_CYCLES - 1)) begin
                                    det_ok[p]    <= det_s[p];
                                    event_reg[p] <= 1'b1;
                                    pcnt[p]      <= 32'h00000000;
                                    if (man) begin
                                        req_reg[p] <= 1'b0;
                                    end
                                    if (!det_s[p] && cadence_on[p]) begin
                                        pstate[p] <= PS_WAIT;
                                    end else if (det_s[p] && req_reg[p+4]) begin
                                        pstate[p] <= PS_CLASSIFY;
                                    end else begin
                                        pstate[p] <= PS_IDLE;
                                    end
                                end
                            end
                            PS_CLASSIFY: begin
                                pcnt[p] <= pcnt[p] + 32'h00000001;
                                if ((man || (semi && det_ok[p] && cls_ok[p])) && pwr_req[p]) begin
                                    pstate[p] <= PS_POWERED;
                                end else if (pcnt[p] == 32'(CLS_CYCLES - 1)) begin
                                    cls_ok[p]      <= cls_s2[p];
                                    event_reg[p+4] <= 1'b1;
                                    if (man) begin
                                        req_reg[p+4] <= 1'b0;
                                    end
                                    pstate[p] <= (auto_m && cls_s2[p]) ? PS_POWERED : PS_IDLE;
                                end
                            end
                            PS_WAIT: begin
                                pcnt[p] <= pcnt[p] + 32'h00000001;
                                if ((man || (semi && det_ok[p] && cls_ok[p])) && pwr_req[p]) begin
                                    pstate[p] <= PS_POWERED;
                                end else if (pcnt[p] >= 32'(CADENCE_CNT - 1)) begin
                                    pstate[p] <= PS_IDLE;
                                end
                            end
                            PS_POWERED: begin
                                if (flt_s2[p]) begin
                                    pstate[p] <= PS_IDLE;
                                    det_ok[p] <= 1'b0;
                                    cls_ok[p] <= 1'b0;
                                    if (semi) begin
                                        req_reg[p]   <= 1'b0;
                                        req_reg[p+4] <= 1'b0;
                                    end
                                end else if (man) begin
                                    req_reg[p]   <= 1'b0;
                                    req_reg[p+4] <= 1'b0;
                                end
                            end
                            default: pstate[p] <= PS_IDLE;
                        endcase
                    end
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    port_power[p]       <= 1'b0;
                    port_detecting[p]   <= 1'b0;
                    port_classifying[p] <= 1'b0;
                end else begin
                    port_power[p]       <= pstate[p] == PS_POWERED && !shut && !glob_rst;
                    port_detecting[p]   <= pstate[p] == PS_DETECT;
                    port_classifying[p] <= pstate[p] == PS_CLASSIFY;
                end
            end
        end
    endgenerate

    // Interrupt pin, low while any event is pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_n_out <= 1'b0;
            int_n_oe  <= 1'b0;
        end else begin
            int_n_out <= 1'b0;
            int_n_oe  <= |event_reg;
        end
    end

    // Read channel
    logic [31:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            REG_STATUS:    rd_mux = {22'h000000, glob_rst_q, class5_enabled, port_power,
                                     address_latched};
            REG_PORT_MODE: rd_mux = {24'h000000, mode_reg};
            REG_DET_CLS:   rd_mux = {24'h000000, req_reg};
            REG_CADENCE:   rd_mux = {28'h0000000, cadence_on};
            REG_POWER_ON:  rd_mux = 32'h00000000;
            REG_RESET:     rd_mux = {28'h0000000, port_rst_req};
            REG_EVENT:     rd_mux = {24'h000000, event_reg};
            default:       rd_mux = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                case (s_axi_araddr)
                    REG_STATUS, REG_PORT_MODE, REG_DET_CLS, REG_CADENCE,
                    REG_POWER_ON, REG_RESET, REG_EVENT: s_axi_rresp <= RESP_OKAY;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : psemc_top

`default_nettype wire

// [sim/psemc_pd_model.sv]
/* Powered-device front end: reports detect and classify results per port.
   Assumes the bench sets which ports hold a valid device. */
`timescale 1ns/1ns
`default_nettype none
module psemc_pd_model (
    input  wire logic [3:0] present,
    output logic      [3:0] det_good,
    output logic      [3:0] cls_good
);
    assign det_good = present;
    assign cls_good = present;
endmodule : psemc_pd_model
`default_nettype wire

// [sim/psemc_monitor.sv]
/* Port-level checker for psemc_top.
   Assumes the sim value 4 for the enable-low count. */
`timescale 1ns/1ns
`default_nettype none
module psemc_monitor (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       en_pin,
    input wire logic       undervoltage_lockout,
    input wire logic       over_temp,
    input wire logic       class5_enable_strap,
    input wire logic       s_axi_bvalid,
    input wire logic [3:0] port_power,
    input wire logic [3:0] port_detecting,
    input wire logic [3:0] port_classifying,
    input wire logic       class5_enabled,
    input wire logic       int_n_out,
    input wire logic       int_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_int_pin_low: assert property (int_n_oe |-> !int_n_out)
        else $error("interrupt pin not low");
    chk_undervoltage_lockout_off: assert property (undervoltage_lockout[*4] |=> ~|port_power && !int_n_oe)
        else $error("power on during lockout");
    chk_undervoltage_lockout_idle: assert property (undervoltage_lockout[*4] |=> ~|port_detecting)
        else $error("probing during lockout");
    chk_en_reset: assert property (!en_pin[*8] |-> ##[0:4] ~|port_power)
        else $error("enable low kept power");
    chk_thermal_off: assert property (over_temp[*4] |=> ~|port_power && ~|port_classifying)
        else $error("active in thermal shutdown");
    chk_strap_latch: assert property ((undervoltage_lockout && $stable(class5_enable_strap))[*4]
        |=> class5_enabled == class5_enable_strap)
        else $error("class5 strap not latched");
    chk_strap_held: assert property ((en_pin && !undervoltage_lockout && !over_temp
        && !s_axi_bvalid)[*6]
        |=> $stable(class5_enabled))
        else $error("strap changed in operation");
    chk_power_no_probe: assert property (~|(port_power & (port_detecting | port_classifying)))
        else $error("powered port probing");
endmodule : psemc_monitor
bind psemc_top psemc_monitor i_mon (.*);
`default_nettype wire

// [sim/psemc_top_tb.sv]
/* Bench for psemc_top over AXI4-Lite.
   Assumes the short sim counts of the enable and cadence timers. */
`timescale 1ns/1ns
`default_nettype none
module psemc_top_tb;
    import psemc_pkg::*;
    logic clk, rst, en_pin, undervoltage_lockout, over_temp, class5_enable_strap;
    logic default_mode_strap, cadence_strap, class5_enabled, int_n_out, int_n_oe;
    logic [3:0] address_straps, det_good, cls_good, power_fault, s_axi_wstrb, pd_on;
    logic [3:0] port_power, port_detecting, port_classifying, address_latched;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int mismatches, n_checks, cyc, i;
    psemc_top #(.EN_LOW_CNT(4), .CADENCE_CNT(20)) i_dut (.*);
    psemc_pd_model i_pd (.present(pd_on), .det_good(det_good), .cls_good(cls_good));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge clk);
        br = s_axi_bresp;
    endtask : wr
    task rc(input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge clk);
        rdat = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 0;
        @(posedge clk);
        chk(rdat, e);
    endtask : rc
    task wt(input logic [3:0] e);
        for (int k = 0; k < 300 && port_power !== e; k++) @(posedge clk);
        chk({28'h0, port_power}, {28'h0, e});
    endtask : wt
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        rst = 1; en_pin = 1; undervoltage_lockout = 0; over_temp = 0; pd_on = 4'h0;
        class5_enable_strap = 0; default_mode_strap = 1; cadence_strap = 1;
        address_straps = 4'hA; power_fault = 4'h0; s_axi_wstrb = 4'hF;
        repeat (20) @(posedge clk);
        rst <= 0;
        repeat (4) @(posedge clk);
        rc(REG_STATUS, 32'h00A);
        chk({28'h0, address_latched}, 32'hA);
        rc(REG_PORT_MODE, 32'hFF);
        rc(REG_DET_CLS, 32'hFF);
        wr(REG_PORT_MODE, 32'h55);
        rc(REG_DET_CLS, 32'h00);
        wr(REG_POWER_ON, 32'h1);
        wt(4'h1);
        wr(REG_RESET, 32'h1);
        wt(4'h0);
        wr(REG_PORT_MODE, 32'h0);
        wr(REG_POWER_ON, 32'h1);
        repeat (8) @(posedge clk);
        chk({28'h0, port_power}, 32'h0);
        wr(REG_PORT_MODE, 32'hFF);
        rc(REG_DET_CLS, 32'h00);
        class5_enable_strap <= 1;
        repeat (8) @(posedge clk);
        rc(REG_STATUS, 32'h00A);
        wr(REG_RESET, 32'h10);
        repeat (4) @(posedge clk);
        rc(REG_STATUS, 32'h10A);
        chk({31'h0, class5_enabled}, 32'h1);
        for (i = 0; i < 3; i++) begin
            wr(REG_PORT_MODE, 32'h55);
            en_pin <= (i != 0); over_temp <= (i == 1); undervoltage_lockout <= (i == 2);
            repeat (10) @(posedge clk);
            en_pin <= 1; over_temp <= 0; undervoltage_lockout <= 0;
            repeat (10) @(posedge clk);
            rc(REG_PORT_MODE, 32'hFF);
        end
        pd_on <= 4'h2;
        wt(4'h2);
        chk({31'h0, int_n_oe}, 32'h1);
        wr(REG_PORT_MODE, 32'hAA);
        chk({28'h0, port_power}, 32'h2);
        power_fault <= 4'h2;
        wt(4'h0);
        power_fault <= 4'h0;
        rc(REG_DET_CLS, 32'hDD);
        wr(REG_POWER_ON, 32'h2);
        repeat (8) @(posedge clk);
        chk({28'h0, port_power}, 32'h0);
        wr(REG_DET_CLS, 32'hFF);
        repeat (60) @(posedge clk);
        chk({28'h0, port_power}, 32'h0);
        wr(REG_POWER_ON, 32'h2);
        wt(4'h2);
        rc(8'h7C, 32'h0);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        wr(8'h7C, 32'h0);
        chk({30'h0, br}, {30'h0, RESP_SLVERR});
        results;
    end
endmodule : psemc_top_tb
`default_nettype wire
